// ---- design/rtis_init_seq.sv ----
// Purpose: I2C master that loads the retimer set-up list after reset
// Assumes: Open-drain SCL/SDA resolved outside; inputs synchronous to aclk
// Notes: AXI4-Lite gives restart control and progress/status readback
//
// Functional notes
// RULE1 - Start at power-up: page 0, crossover mode
// RULE2 - Write 0x7B to 0x0A blocking plug pass-through
// RULE3 - Write 0x80 to 0x0D, sideband clock enable
// RULE4 - Max swing 0x6D to 0x0C, then 0x00
// RULE5 - Write 0x11 to 0x10 for PRBS23 mode
// RULE6 - 0xF1 to 0x16, then select page 1
// RULE7 - PLL set-up, overrides 0xA1 and 0xA4
// RULE8 - Lane 0 clock source, fixed recovery setup
// RULE9 - Write 0xF0 to 0x10, outputs off
// RULE10 - 0x30 to 0x11, then 0x00 to 0x14
// RULE11 - Write 0x03 to 0x12 for slew/swing
// RULE12 - Pulse 0x13 with 0xFF then 0x00
// RULE13 - Receivers: 0xE0 to 0x30, 0x32/0x31 zero
// RULE14 - Equaliser 0x08 to 0x4D, fixed 0x01 0x4C
// RULE15 - Offset correction, pulse 0x32, load 0x33
// RULE16 - Page 0, re-enable pass-through, page 1
// RULE17 - Serial clock at 400 kHz or faster
// RULE18 - Loader does all set-up unaided
// RULE19 - One address+data write each, strictly ordered
// RULE20 - Done after last ack; error stop on NACK
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rtis_map.svh"
module rtis_init_seq
    import rtis_pkg::*;
#(
    parameter int unsigned QTR_CYCLES = `RTIS_QTR_CYCLES,
    parameter logic [6:0] DEV_ADDR = `RTIS_DEV_ADDR
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic init_busy,
    output logic init_done,
    output logic init_error
);

    rtis_state_t state;
    logic [1:0] phase;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [7:0] shreg;
    logic [5:0] idx;
    logic nack;
    logic start_pend;
    logic tick;
    logic adv;
    logic [15:0] rom_q;
    logic aw_held;
    logic w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic commit;
    logic sw_start;
    logic [7:0] next_byte;

    rtis_tick_div #(.DIV(QTR_CYCLES)) u_div ( // RULE17
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    rtis_seq_rom u_rom (
        .aclk(aclk),
        .addr(idx),
        .q(rom_q)
    );

    // Open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;

    // Released SCL held low by the retimer stretches the bit
    assign adv = tick && !(!scl_oe && !scl_i);

    always_comb begin
        if (byte_cnt == 2'h0) begin
            next_byte = rom_q[15:8];
        end else begin
            next_byte = rom_q[7:0];
        end
    end

    // Software restart; power-up start needs no software at all
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_pend <= 1'b1; // RULE1 RULE18
        end else if (sw_start) begin
            start_pend <= 1'b1;
        end else if (state == S_DONE || state == S_ERROR || state == S_IDLE) begin
            start_pend <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= S_IDLE;
            phase <= 2'h0;
            bit_cnt <= 3'h0;
            byte_cnt <= 2'h0;
            shreg <= 8'h00;
            idx <= 6'h00;
            nack <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                S_IDLE, S_DONE, S_ERROR: begin
                    if (start_pend) begin
                        state <= S_FETCH; // RULE18
                        idx <= 6'h00;
                        nack <= 1'b0;
                    end
                end
                S_FETCH: begin
                    // ROM word settles a cycle after idx; tick is later
                    if (adv) begin
                        shreg <= {DEV_ADDR, 1'b0}; // RULE19
                        byte_cnt <= 2'h0;
                        bit_cnt <= 3'h0;
                        phase <= 2'h0;
                        state <= S_START;
                    end
                end
                S_START: begin
                    if (adv) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            sda_oe <= 1'b1;
                        end else if (phase == 2'h1) begin
                            scl_oe <= 1'b1;
                            phase <= 2'h0;
                            state <= S_BIT;
                        end
                    end
                end
                S_BIT: begin
                    if (adv) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            sda_oe <= !shreg[7];
                        end else if (phase == 2'h1) begin
                            scl_oe <= 1'b0;
                        end else if (phase == 2'h3) begin
                            scl_oe <= 1'b1;
                            shreg <= {shreg[6:0], 1'b0};
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7) begin
                                state <= S_ACK;
                            end
                        end
                    end
                end
                S_ACK: begin
                    if (adv) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            sda_oe <= 1'b0;
                        end else if (phase == 2'h1) begin
                            scl_oe <= 1'b0;
                        end else if (phase == 2'h2) begin
                            nack <= sda_i; // RULE20
                        end else begin
                            scl_oe <= 1'b1;
                            if (nack || byte_cnt == 2'h2) begin
                                state <= S_STOP; // RULE19 RULE20
                            end else begin
                                shreg <= next_byte; // RULE19
                                byte_cnt <= byte_cnt + 2'h1;
                                state <= S_BIT;
                            end
                        end
                    end
                end
                S_STOP: begin
                    if (adv) begin
                        phase <= phase + 2'h1;
                        if (phase == 2'h0) begin
                            sda_oe <= 1'b1;
                        end else if (phase == 2'h1) begin
                            scl_oe <= 1'b0;
                        end else if (phase == 2'h2) begin
                            sda_oe <= 1'b0;
                        end else if (nack) begin
                            state <= S_ERROR; // RULE20
                        end else if (idx == `RTIS_LAST_IDX) begin
                            state <= S_DONE; // RULE20
                        end else begin
                            idx <= idx + 6'h01; // RULE19
                            state <= S_FETCH;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    assign init_busy = !(state == S_IDLE || state == S_DONE || state == S_ERROR);
    assign init_done = (state == S_DONE); // RULE20
    assign init_error = (state == S_ERROR); // RULE20

    // AXI4-Lite write side: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign commit = aw_held && w_held && !s_axi_bvalid;
    assign sw_start = commit && aw_addr == `RTIS_OFS_CTRL && w_strb[0]
        && w_data[`RTIS_CTRL_START] && !init_busy;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (commit) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (commit) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RTIS_RESP_OKAY;
        end else if (commit) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `RTIS_OFS_CTRL || aw_addr == `RTIS_OFS_STATUS) begin
                s_axi_bresp <= `RTIS_RESP_OKAY;
            end else begin
                s_axi_bresp <= `RTIS_RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read side: one read at a time, answer a cycle after the address
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RTIS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RTIS_RESP_OKAY;
            if (s_axi_araddr == `RTIS_OFS_CTRL) begin
                s_axi_rdata[`RTIS_CTRL_START] <= start_pend;
            end else if (s_axi_araddr == `RTIS_OFS_STATUS) begin
                s_axi_rdata[`RTIS_ST_BUSY] <= init_busy;
                s_axi_rdata[`RTIS_ST_DONE] <= init_done;
                s_axi_rdata[`RTIS_ST_ERROR] <= init_error;
                s_axi_rdata[`RTIS_ST_IDX_LSB +: `RTIS_IDX_W] <= idx;
            end else begin
                s_axi_rresp <= `RTIS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    sequence nack_seen_s;
        state == S_ACK && adv && phase == 2'h2 && sda_i;
    endsequence

    sequence error_reached_s;
        ##[1:80] state == S_ERROR;
    endsequence

    AST_AUTO_START: assert property (@(posedge aclk) // RULE1
        $rose(aresetn) |-> ##[1:2] state == S_FETCH)
        else $error("loader did not start after reset");

    AST_TICK_SPACING: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
        tick |-> ##12 tick)
        else $error("serial clock quarter period wrong");

    AST_NACK_STOPS: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
        nack_seen_s |-> error_reached_s)
        else $error("missing acknowledge did not end in error");

    AST_ERROR_HOLDS: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
        (state == S_ERROR && !start_pend) |=> state == S_ERROR && !scl_oe && !sda_oe)
        else $error("loader moved after error");

    AST_DONE_AT_LAST: assert property (@(posedge aclk) disable iff (!aresetn) // RULE20
        $rose(init_done) |-> idx == `RTIS_LAST_IDX && !nack)
        else $error("done before last write");

    AST_IN_ORDER: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
        ($changed(idx) && $past(state) == S_STOP) |-> idx == $past(idx) + 6'h01)
        else $error("list entry skipped");

    AST_SDA_STABLE: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
        (state == S_BIT && !scl_oe && !$past(scl_oe)) |-> $stable(sda_oe))
        else $error("data changed while clock high");

    AST_START_ONLY: assert property (@(posedge aclk) disable iff (!aresetn) // RULE19
        ($rose(sda_oe) && !scl_oe) |-> $past(state) == S_START || $past(state) == S_STOP)
        else $error("stray start condition");

    AST_WRITE_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> s_axi_bvalid && !aw_held && !w_held)
        else $error("write response missing");

endmodule : rtis_init_seq
`default_nettype wire

// ---- design/rtis_map.svh ----
// Purpose: Named constants for the retimer init sequencer
// Assumes: 20 MHz system clock, 32-bit AXI4-Lite register port
// Notes: Included by every design file that needs a number
`ifndef RTIS_MAP_SVH
`define RTIS_MAP_SVH

`define RTIS_CLK_KHZ 20000
`define RTIS_SCL_KHZ 400
// Quarter of an SCL period, rounded down so SCL never runs slower
`define RTIS_QTR_CYCLES (`RTIS_CLK_KHZ / (4 * `RTIS_SCL_KHZ))

`define RTIS_SEQ_LEN 38
`define RTIS_IDX_W 6
`define RTIS_LAST_IDX 6'h25
// Arbitrary target address; boards strap their own
`define RTIS_DEV_ADDR 7'h2c

`define RTIS_OFS_CTRL 4'h0
`define RTIS_OFS_STATUS 4'h4
`define RTIS_CTRL_START 0
`define RTIS_ST_BUSY 0
`define RTIS_ST_DONE 1
`define RTIS_ST_ERROR 2
`define RTIS_ST_IDX_LSB 8

`define RTIS_RESP_OKAY 2'h0
`define RTIS_RESP_SLVERR 2'h2

`endif

// ---- design/rtis_pkg.sv ----
// Purpose: Types shared by the retimer init sequencer
// Assumes: Nothing beyond the map header
// Notes: States are one-hot
`default_nettype none
package rtis_pkg;

    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_FETCH = 8'h02,
        S_START = 8'h04,
        S_BIT = 8'h08,
        S_ACK = 8'h10,
        S_STOP = 8'h20,
        S_DONE = 8'h40,
        S_ERROR = 8'h80
    } rtis_state_t;

endpackage : rtis_pkg
`default_nettype wire

// ---- design/rtis_tick_div.sv ----
// Purpose: Divides the system clock into a one-cycle enable pulse
// Assumes: DIV of at least 2
// Notes: Free running from reset release
`timescale 1ns/1ps
`default_nettype none
module rtis_tick_div #(
    parameter int unsigned DIV = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);

    logic [7:0] count;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (count == 8'(DIV - 1)) begin
            count <= 8'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end

endmodule : rtis_tick_div
`default_nettype wire

// ---- design/rtis_seq_rom.sv ----
// Purpose: Ordered list of retimer writes, register address then data
// Assumes: Address held stable while the word is in use
// Notes: Read data comes out of a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module rtis_seq_rom (
    input wire logic aclk,
    input wire logic [5:0] addr,
    output logic [15:0] q
);

    always_ff @(posedge aclk) begin
        case (addr)
            6'h00: q <= 16'hff00; // RULE1
            6'h01: q <= 16'h0936; // RULE1
            6'h02: q <= 16'h0a7b; // RULE2
            6'h03: q <= 16'h0d80; // RULE3
            6'h04: q <= 16'h0c6d; // RULE4
            6'h05: q <= 16'h0c00; // RULE4
            6'h06: q <= 16'h1011; // RULE5
            6'h07: q <= 16'h16f1; // RULE6
            6'h08: q <= 16'hff01; // RULE6
            6'h09: q <= 16'h0002; // RULE7
            6'h0a: q <= 16'h0480; // RULE7
            6'h0b: q <= 16'h0500; // RULE7
            6'h0c: q <= 16'h0800; // RULE7
            6'h0d: q <= 16'h0d02; // RULE8
            6'h0e: q <= 16'h0e03; // RULE8
            6'h0f: q <= 16'h0101; // RULE7
            6'h10: q <= 16'h023f; // RULE7
            6'h11: q <= 16'h0b33; // RULE7
            6'h12: q <= 16'ha102; // RULE7
            6'h13: q <= 16'ha402; // RULE7
            6'h14: q <= 16'h10f0; // RULE9
            6'h15: q <= 16'h1130; // RULE10
            6'h16: q <= 16'h1400; // RULE10
            6'h17: q <= 16'h1203; // RULE11
            6'h18: q <= 16'h13ff; // RULE12
            6'h19: q <= 16'h1300; // RULE12
            6'h1a: q <= 16'h30e0; // RULE13
            6'h1b: q <= 16'h3200; // RULE13
            6'h1c: q <= 16'h3100; // RULE13
            6'h1d: q <= 16'h4d08; // RULE14
            6'h1e: q <= 16'h4c01; // RULE14
            6'h1f: q <= 16'h3401; // RULE15
            6'h20: q <= 16'h32f0; // RULE15
            6'h21: q <= 16'h3200; // RULE15
            6'h22: q <= 16'h33f0; // RULE15
            6'h23: q <= 16'hff00; // RULE16
            6'h24: q <= 16'h0a3b; // RULE16
            default: q <= 16'hff01; // RULE16
        endcase
    end

endmodule : rtis_seq_rom
`default_nettype wire

// ---- bench/rtis_target_model.sv ----
// Purpose: Behavioural I2C target standing in for the retimer
// Assumes: SCL and SDA are resolved wired-AND lines with pull-ups
// Notes: Reports each fully acked three-byte write on frame_valid
`timescale 1ns/1ps
`default_nettype none
module rtis_target_model #(
    parameter logic [6:0] ADDR = 7'h2c
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic scl,
    input wire logic sda,
    input wire logic stretch_en,
    input wire logic [7:0] nack_frame,
    input wire logic [1:0] nack_byte,
    output logic scl_pull,
    output logic sda_pull,
    output logic frame_valid,
    output logic [23:0] frame_data
);
    logic scl_q, sda_q, nacked, in_frame, ack_ok;
    logic [3:0] bit_n;
    logic [1:0] byte_n;
    logic [7:0] shreg, frame_n;
    logic [23:0] acc;
    logic [5:0] hold;

    // A wrong device address is refused, as the real part would
    assign ack_ok = (byte_n != 2'h0 || shreg == {ADDR, 1'b0})
        && !(frame_n == nack_frame && byte_n == nack_byte);
    assign scl_pull = hold != 6'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold <= 6'h00;
        end else if (stretch_en && !scl && scl_q) begin
            hold <= 6'h28;  // Longer than the master's own low phase
        end else if (hold != 6'h00) begin
            hold <= hold - 6'h01;
        end
    end

    always_ff @(posedge aclk) begin
        scl_q <= scl;
        sda_q <= sda;
        frame_valid <= 1'b0;
        if (!aresetn) begin
            in_frame <= 1'b0;
            nacked <= 1'b0;
            sda_pull <= 1'b0;
            frame_n <= 8'h00;
            bit_n <= 4'h0;
            byte_n <= 2'h0;
        end else if (scl && scl_q && sda_q && !sda) begin
            in_frame <= 1'b1;
            nacked <= 1'b0;
            bit_n <= 4'h0;
            byte_n <= 2'h0;
        end else if (scl && scl_q && !sda_q && sda) begin
            frame_valid <= in_frame && !nacked && byte_n == 2'h3;
            frame_data <= acc;
            frame_n <= frame_n + 8'h01;
            in_frame <= 1'b0;
        end else if (in_frame && scl && !scl_q) begin
            if (bit_n < 4'h8) shreg <= {shreg[6:0], sda};
            bit_n <= bit_n + 4'h1;
        end else if (in_frame && !scl && scl_q) begin
            if (bit_n == 4'h8) begin
                sda_pull <= ack_ok;
                nacked <= nacked || !ack_ok;
            end else if (bit_n == 4'h9) begin
                sda_pull <= 1'b0;
                bit_n <= 4'h0;
                byte_n <= byte_n + 2'h1;
                acc <= {acc[15:0], shreg};
            end
        end
    end
endmodule : rtis_target_model
`default_nettype wire

// ---- bench/test_retimer_i2c_init_sequencer.sv ----
// Purpose: Self-checking bench for the retimer init sequencer
// Assumes: Default quarter period, so an SCL period is 48 cycles
// Notes: Inputs change by non-blocking assignment after rising edges
`timescale 1ns/1ps
`default_nettype none
`include "rtis_map.svh"
module test_retimer_i2c_init_sequencer;
    localparam logic [7:0] ADDR_BYTE = {`RTIS_DEV_ADDR, 1'b0};
    localparam logic [15:0] SEQ_TBL [38] = '{
        16'hff00, 16'h0936, 16'h0a7b, 16'h0d80,
        16'h0c6d, 16'h0c00, 16'h1011, 16'h16f1, 16'hff01,
        16'h0002, 16'h0480, 16'h0500, 16'h0800,
        16'h0d02, 16'h0e03,
        16'h0101, 16'h023f, 16'h0b33, 16'ha102, 16'ha402,
        16'h10f0, 16'h1130, 16'h1400, 16'h1203,
        16'h13ff, 16'h1300,
        16'h30e0, 16'h3200, 16'h3100, 16'h4d08, 16'h4c01,
        16'h3401, 16'h32f0, 16'h3200, 16'h33f0,
        16'hff00, 16'h0a3b, 16'hff01
    };
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic stretch_en = 1'b0;
    logic [7:0] nack_frame = 8'hff;
    logic [1:0] nack_byte = 2'h0;
    logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe;
    logic init_busy, init_done, init_error, scl_pull, sda_pull, frame_valid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [23:0] frame_data;
    logic [23:0] rx_q [$];
    int fail_count = 0;
    int total_checks = 0;
    int scl_cnt = 0, scl_bad = 0, scl_ok = 0;
    logic scl_prev = 1'b1;
    // Pull-ups: a released line reads high
    wire scl_line = !((scl_oe && !scl_o) || scl_pull);
    wire sda_line = !((sda_oe && !sda_o) || sda_pull);

    always #25 aclk = ~aclk;

    rtis_init_seq i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .init_busy(init_busy), .init_done(init_done), .init_error(init_error));

    rtis_target_model #(.ADDR(`RTIS_DEV_ADDR)) i_target (.aclk(aclk), .aresetn(aresetn),
        .scl(scl_line), .sda(sda_line), .stretch_en(stretch_en), .nack_frame(nack_frame),
        .nack_byte(nack_byte), .scl_pull(scl_pull), .sda_pull(sda_pull),
        .frame_valid(frame_valid), .frame_data(frame_data));

    // Gaps between frames are longer than 66 cycles and are not periods
    always @(posedge aclk) begin
        if (frame_valid) rx_q.push_back(frame_data);
        scl_prev <= scl_line;
        scl_cnt <= scl_cnt + 1;
        if (scl_line && !scl_prev) begin
            scl_cnt <= 1;
            if (!stretch_en && scl_cnt > 50 && scl_cnt < 67) scl_bad <= scl_bad + 1;
            else if (scl_cnt <= 50) scl_ok <= scl_ok + 1;
        end
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic check_frames(input int cnt);
        int k;
        k = rx_q.size();
        check("frame count", cnt, k);
        for (int i = 0; i < cnt && i < k; i++) begin
            check("frame", {8'h00, ADDR_BYTE, SEQ_TBL[i]}, {8'h00, rx_q[i]});
        end
    endtask : check_frames

    task automatic axi_write(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] resp);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dat;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            dat = rdata;
            resp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : axi_read

    // Only the watchdog ends a hang here
    task automatic wait_end();
        while (init_busy !== 1'b1) begin
            @(negedge aclk);
        end
        while (init_busy === 1'b1) begin
            @(negedge aclk);
        end
    endtask : wait_end

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    initial begin
        repeat (90000) @(posedge aclk);
        fail_count++;
        $display("[FAIL] watchdog expected finish seen timeout");
        test_done();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(negedge aclk);
        check("busy after reset", 32'h1, init_busy);
        axi_read(4'h0, d, r);
        check("ctrl reset value", 32'h0, d);
        check("ctrl rresp", 32'h0, r);
        axi_read(4'h8, d, r);
        check("unmapped rdata", 32'h0, d);
        check("unmapped rresp", 32'h2, r);
        axi_write(4'h8, 32'h1, r);
        check("unmapped bresp", 32'h2, r);
        axi_write(4'h4, 32'hffff_ffff, r);
        check("status write bresp", 32'h0, r);
        axi_read(4'h4, d, r);
        check("status while running", 32'h1, d[2:0]);
        wait_end();
        check_frames(38);
        axi_read(4'h4, d, r);
        check("status after list", 32'h0000_2502, d);
        check("scl slow periods", 32'h0, scl_bad);
        check("scl periods seen", 32'h1, scl_ok > 0);
        $display("test full_list finished");
        rx_q.delete();
        nack_frame <= 8'h2b;
        nack_byte <= 2'h1;
        axi_write(4'h0, 32'h1, r);
        check("restart bresp", 32'h0, r);
        wait_end();
        check_frames(5);
        check("error flag", 32'h1, init_error);
        check("done after nack", 32'h0, init_done);
        axi_read(4'h4, d, r);
        check("status after nack", 32'h0000_0504, d);
        $display("test nack_register_byte finished");
        rx_q.delete();
        stretch_en <= 1'b1;
        nack_frame <= 8'h2f;
        nack_byte <= 2'h2;
        axi_write(4'h0, 32'h1, r);
        axi_write(4'h0, 32'h1, r);
        check("restart while busy bresp", 32'h0, r);
        wait_end();
        check_frames(3);
        axi_read(4'h4, d, r);
        check("status after data nack", 32'h0000_0304, d);
        $display("test stretch_and_data_nack finished");
        test_done();
    end
endmodule : test_retimer_i2c_init_sequencer
`default_nettype wire
